// ### logic/eipm_params.svh
// constants for the external-input positioning block
`ifndef EIPM_PARAMS_SVH
`define EIPM_PARAMS_SVH

// register byte offsets
`define EIPM_OFF_MODE       12'h000
`define EIPM_OFF_CMD        12'h004
`define EIPM_OFF_SETVAL     12'h008
`define EIPM_OFF_POS_ONE    12'h00c
`define EIPM_OFF_POS_TWO    12'h010
`define EIPM_OFF_TARGET     12'h014
`define EIPM_OFF_STATUS     12'h018
`define EIPM_OFF_CONFIG     12'h01c

// mode field values
`define EIPM_MODE_SHUTTLE   2'h0
`define EIPM_MODE_TWO_POINT 2'h1
`define EIPM_MODE_REMOTE    2'h2
`define EIPM_MODE_OFF       2'h3

// command register bits
`define EIPM_CMD_STOP_BIT   0
`define EIPM_CMD_START_BIT  1
`define EIPM_CMD_END_BIT    2
`define EIPM_CMD_CTRL14_BIT 14

// status bits
`define EIPM_ST_BUSY_BIT     0
`define EIPM_ST_SHUTTLE_BIT  1
`define EIPM_ST_LOCK_BIT     2
`define EIPM_ST_TWO_PT_BIT   3
`define EIPM_ST_REMOTE_BIT   4
`define EIPM_ST_JOG_BIT      5

// config: external-input setting, 0 = key
`define EIPM_CFG_KEY        2'h0

// debounce times
`define EIPM_CLK_HZ         10000000
`define EIPM_TWO_PT_DB_MS   390
`define EIPM_REMOTE_DB_MS   16
// scale the clock to per-millisecond first so the product fits an int
`define EIPM_TWO_PT_DB_CYC  (`EIPM_TWO_PT_DB_MS * (`EIPM_CLK_HZ / 1000))
`define EIPM_REMOTE_DB_CYC  (`EIPM_REMOTE_DB_MS * (`EIPM_CLK_HZ / 1000))

`endif

// ### logic/eipm_pkg.sv
// types for the external-input positioning block
package eipm_pkg;
  typedef enum logic [1:0] {
    eipm_idle_s,
    eipm_move_s,
    eipm_shuttle_s
  } eipm_state_t;
endpackage

// ### logic/eipm_top.sv
// external-input positioning mode controller with apb registers
//
// Contract
// RULE1 - mode field: 0 shuttle, 1 two-point, 2 remote target, 3 off
// RULE2 - after reset shuttle mode is selected, shuttling not running
// RULE3 - one mode at a time; mode may change at any moment
// RULE4 - shuttle mode: both inputs shuttle, one input jogs, none idles
// RULE5 - inputs beat bus; bus start/stop only with both inputs low
// RULE6 - writing 1 to the shuttle start entry starts shuttling
// RULE7 - shuttle ends by bus end entry 0 or both inputs inactive
// RULE8 - shuttle alternates reversal points, creep before each, no loop
// RULE9 - shuttle end goes to set value; set value writable meanwhile
// RULE10 - two-point: a targets first, b second; both or none idle
// RULE11 - two-point activation loads set value, starts, finishes, holds
// RULE12 - two-point: single input held blocks set-value and drive writes
// RULE13 - status bit 3 follows input a or b in two-point mode; the code sets it only while exactly one of the two inputs is high
// RULE14 - two-point debounce of both inputs lies within 390..394 ms
// RULE15 - remote mode: input a starts move to target, b ignored
// RULE16 - target volatile, reset 0 and locked; a target write unlocks
// RULE17 - remote move lasts only while a active; drop stops and locks
// RULE18 - reaching the remote target locks it again
// RULE19 - remote a held blocks writes except motor stop; mode, config, pos_one and pos_two writes still pass
// RULE20 - status bit 4 follows input a in remote mode
// RULE21 - remote debounce of input a lies within 16..20 ms
// RULE22 - off mode ignores inputs, otherwise standard behaviour
// RULE23 - remote target may be overwritten at any time; target writes are ignored while a_held
// RULE24 - jog from inputs only when input setting is key
// RULE25 - motor stop entry or control bit 14 stops any positioning
// RULE26 - inputs synchronised, activation is rising edge of debounced level
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "eipm_params.svh"

module eipm_top #(
  parameter int POS_W      = 16,
  parameter int TWO_PT_DB  = `EIPM_TWO_PT_DB_CYC,
  parameter int REMOTE_DB  = `EIPM_REMOTE_DB_CYC
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              in_a,
  input  wire logic              in_b,
  input  wire logic              engine_done,
  output logic                   engine_start,
  output logic                   engine_stop,
  output logic                   engine_creep,
  output logic [POS_W-1:0]       engine_target,
  output logic                   jog_a,
  output logic                   jog_b
);

  // ----------------------------------------------------------------
  // synchronisers and debounce
  // ----------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       deb_a;
  logic       deb_b;
  logic [22:0] cnt_a;
  logic [22:0] cnt_b;
  logic [1:0]  mode;
  logic [22:0] db_len;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {sync_a[1:0], in_a}; // RULE26
      sync_b <= {sync_b[1:0], in_b}; // RULE26
    end
  end

  // remote mode needs a quick response; two-point filters switch chatter
  assign db_len = (mode == `EIPM_MODE_REMOTE) ? 23'(REMOTE_DB) // RULE21
                                              : 23'(TWO_PT_DB); // RULE14

  // a level is accepted once stages two and three agree for db_len cycles
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_a <= 23'h0;
      deb_a <= 1'b0;
    end else if ((sync_a[2] != sync_a[1]) || (sync_a[2] == deb_a)) begin
      cnt_a <= 23'h0;
    end else if (cnt_a >= db_len - 23'h1) begin
      cnt_a <= 23'h0;
      deb_a <= sync_a[2];
    end else begin
      cnt_a <= cnt_a + 23'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_b <= 23'h0;
      deb_b <= 1'b0;
    end else if ((sync_b[2] != sync_b[1]) || (sync_b[2] == deb_b)) begin
      cnt_b <= 23'h0;
    end else if (cnt_b >= db_len - 23'h1) begin
      cnt_b <= 23'h0;
      deb_b <= sync_b[2];
    end else begin
      cnt_b <= cnt_b + 23'h1;
    end
  end

  logic deb_a_q;
  logic deb_b_q;
  logic rise_a;
  logic rise_b;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      deb_a_q <= 1'b0;
      deb_b_q <= 1'b0;
    end else begin
      deb_a_q <= deb_a;
      deb_b_q <= deb_b;
    end
  end
  assign rise_a = deb_a & ~deb_a_q; // RULE26
  assign rise_b = deb_b & ~deb_b_q; // RULE26

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [POS_W-1:0] set_value;
  logic [POS_W-1:0] pos_one;
  logic [POS_W-1:0] pos_two;
  logic [POS_W-1:0] target;
  logic [1:0]       input_cfg;
  logic             lock;
  logic             wr;
  logic             in_off;
  logic             one_held;
  logic             a_held;
  logic             bus_block;
  logic             both_low;
  logic             stop_req;
  logic             start_req;
  logic             end_req;

  assign wr = psel & penable & pwrite & pready;
  assign in_off   = (mode == `EIPM_MODE_OFF); // RULE22
  assign one_held = (mode == `EIPM_MODE_TWO_POINT) && (deb_a ^ deb_b);
  assign a_held   = (mode == `EIPM_MODE_REMOTE) && deb_a;
  assign bus_block = one_held | a_held; // RULE12 RULE19
  // off mode ignores the pins, so they count as inactive there
  assign both_low = in_off | (~deb_a & ~deb_b); // RULE5

  assign stop_req = wr && (paddr == `EIPM_OFF_CMD) &&
                    (pwdata[`EIPM_CMD_STOP_BIT] ||
                     pwdata[`EIPM_CMD_CTRL14_BIT]); // RULE25 RULE19
  assign start_req = wr && (paddr == `EIPM_OFF_CMD) && !bus_block &&
                     ((mode == `EIPM_MODE_SHUTTLE) || in_off) &&
                     pwdata[`EIPM_CMD_START_BIT] && both_low; // RULE6 RULE5
  // end entry written as 0 while the command word is written
  assign end_req = wr && (paddr == `EIPM_OFF_CMD) && !bus_block &&
                   !pwdata[`EIPM_CMD_END_BIT] &&
                   !pwdata[`EIPM_CMD_START_BIT] && both_low; // RULE7 RULE5

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `EIPM_OFF_CONFIG);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode      <= `EIPM_MODE_SHUTTLE; // RULE2
      input_cfg <= `EIPM_CFG_KEY;
      pos_one   <= '0;
      pos_two   <= '0;
    end else if (wr) begin
      case (paddr)
        `EIPM_OFF_MODE:    mode      <= pwdata[1:0]; // RULE1 RULE3
        `EIPM_OFF_CONFIG:  input_cfg <= pwdata[1:0];
        `EIPM_OFF_POS_ONE: pos_one   <= pwdata[POS_W-1:0];
        `EIPM_OFF_POS_TWO: pos_two   <= pwdata[POS_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // positioning control
  // ----------------------------------------------------------------
  eipm_pkg::eipm_state_t state;
  logic remote_move;
  logic toward_two;
  logic tp_start;
  logic rm_start;
  logic shuttle_on;
  logic shuttle_src_pins;

  assign tp_start = (mode == `EIPM_MODE_TWO_POINT) &&
                    ((rise_a & ~deb_b) | (rise_b & ~deb_a)); // RULE10
  assign rm_start = (mode == `EIPM_MODE_REMOTE) && rise_a && !lock; // RULE15 RULE16
  assign shuttle_on = (mode == `EIPM_MODE_SHUTTLE) && deb_a && deb_b; // RULE4

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      set_value <= '0;
    end else if (tp_start) begin
      set_value <= (deb_a ? pos_one : pos_two); // RULE11
    end else if (rm_start) begin
      set_value <= target;
    end else if (wr && paddr == `EIPM_OFF_SETVAL && !bus_block) begin
      set_value <= pwdata[POS_W-1:0]; // RULE9 RULE12
    end
  end

  // the target lives only in volatile state: reset clears and locks it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      target <= '0; // RULE16
      lock   <= 1'b1; // RULE16
    end else begin
      if (wr && paddr == `EIPM_OFF_TARGET && !a_held) begin
        target <= pwdata[POS_W-1:0]; // RULE23 RULE19
        lock   <= 1'b0; // RULE16
      end
      // a cancel in the same cycle as a target write wins
      if (state == eipm_pkg::eipm_move_s && remote_move &&
          (engine_done || !deb_a || stop_req)) begin
        lock <= 1'b1; // RULE17 RULE18
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state         <= eipm_pkg::eipm_idle_s;
      remote_move   <= 1'b0;
      toward_two    <= 1'b0;
      engine_start  <= 1'b0;
      engine_stop   <= 1'b0;
      engine_creep  <= 1'b0;
      engine_target <= '0;
    end else begin
      engine_start <= 1'b0;
      engine_stop  <= 1'b0;
      case (state)
        eipm_pkg::eipm_idle_s: begin
          if (stop_req) begin
            engine_stop <= 1'b1;
          end else if (shuttle_on || start_req) begin
            state         <= eipm_pkg::eipm_shuttle_s;
            toward_two    <= 1'b0;
            engine_target <= pos_one; // RULE8
            engine_creep  <= 1'b1; // RULE8
            engine_start  <= 1'b1;
          end else if (tp_start || rm_start) begin
            state         <= eipm_pkg::eipm_move_s;
            remote_move   <= rm_start;
            engine_target <= tp_start ? (deb_a ? pos_one : pos_two)
                                      : target; // RULE11
            engine_creep  <= 1'b0;
            engine_start  <= 1'b1;
          end
        end
        eipm_pkg::eipm_move_s: begin
          // two-point moves run on after the input drops
          if (stop_req || (remote_move && !deb_a)) begin
            state       <= eipm_pkg::eipm_idle_s; // RULE17 RULE25
            engine_stop <= 1'b1;
            remote_move <= 1'b0;
          end else if (engine_done) begin
            state       <= eipm_pkg::eipm_idle_s; // RULE11 RULE18
            remote_move <= 1'b0;
          end
        end
        eipm_pkg::eipm_shuttle_s: begin
          if (stop_req || (mode != `EIPM_MODE_SHUTTLE && !in_off)) begin
            state        <= eipm_pkg::eipm_idle_s; // RULE25 RULE3
            engine_stop  <= 1'b1;
            engine_creep <= 1'b0;
          end else if (end_req || (both_low && !start_req &&
                       !(deb_a | deb_b) && shuttle_src_pins)) begin
            state         <= eipm_pkg::eipm_move_s; // RULE7 RULE9
            engine_target <= set_value; // RULE9
            engine_creep  <= 1'b0;
            engine_start  <= 1'b1;
          end else if (engine_done) begin
            toward_two    <= ~toward_two; // RULE8
            engine_target <= toward_two ? pos_one : pos_two;
            engine_start  <= 1'b1;
          end
        end
        default: state <= eipm_pkg::eipm_idle_s;
      endcase
    end
  end

  // remember whether the pins started the shuttle, so release ends it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      shuttle_src_pins <= 1'b0;
    end else if (state == eipm_pkg::eipm_idle_s) begin
      shuttle_src_pins <= shuttle_on;
    end
  end

  // ----------------------------------------------------------------
  // jog, status and read back
  // ----------------------------------------------------------------
  logic jog_ok;
  assign jog_ok = (mode == `EIPM_MODE_SHUTTLE) &&
                  (input_cfg == `EIPM_CFG_KEY) && (deb_a ^ deb_b); // RULE24 RULE4

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      jog_a <= 1'b0;
      jog_b <= 1'b0;
    end else begin
      jog_a <= jog_ok & rise_a;
      jog_b <= jog_ok & rise_b;
    end
  end

  logic [31:0] status;
  always_comb begin
    status = 32'h0;
    status[`EIPM_ST_BUSY_BIT]    = (state != eipm_pkg::eipm_idle_s);
    status[`EIPM_ST_SHUTTLE_BIT] = (state == eipm_pkg::eipm_shuttle_s);
    status[`EIPM_ST_LOCK_BIT]    = lock;
    status[`EIPM_ST_TWO_PT_BIT]  = one_held; // RULE13
    status[`EIPM_ST_REMOTE_BIT]  = a_held; // RULE20
    status[`EIPM_ST_JOG_BIT]     = jog_ok;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `EIPM_OFF_MODE:    prdata <= {30'h0, mode};
        `EIPM_OFF_SETVAL:  prdata <= 32'(set_value);
        `EIPM_OFF_POS_ONE: prdata <= 32'(pos_one);
        `EIPM_OFF_POS_TWO: prdata <= 32'(pos_two);
        `EIPM_OFF_TARGET:  prdata <= 32'(target);
        `EIPM_OFF_STATUS:  prdata <= status; // RULE13 RULE5
        `EIPM_OFF_CONFIG:  prdata <= {30'h0, input_cfg};
        default:           prdata <= 32'h0;
      endcase
    end
  end

endmodule // eipm_top

// ### dv/eipm_engine_model.sv
// stand-in for the positioning engine behind the block
`timescale 1ns/1ps
module eipm_engine_model #(
  parameter int MOVE_CYC = 60
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic engine_start,
  input  wire logic engine_stop,
  output logic      engine_done
);
  int left;
  // a fresh start wins over a stop in the same cycle, as a new set
  // value restarts the move right after aborting the old one
  always_ff @(posedge clock) begin
    engine_done <= 1'b0;
    if (sys_rst) left <= 0;
    else if (engine_start) left <= MOVE_CYC;
    else if (engine_stop) left <= 0;
    else if (left > 0) begin
      left <= left - 1;
      engine_done <= (left == 1);
    end
  end
endmodule // eipm_engine_model

// ### dv/eipm_chk.sv
// port assertions for the external-input positioning block
`timescale 1ns/1ps
module eipm_chk (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        engine_start,
  input wire logic        engine_stop,
  input wire logic        engine_creep,
  input wire logic        jog_a,
  input wire logic        jog_b
);
  // ----------------------------------------------------------
  // shadow of mode and input setting, seen from the bus
  // ----------------------------------------------------------
  logic [1:0] mode_q;
  logic [1:0] cfg_q;
  logic       wr_acc;
  assign wr_acc = psel && penable && pready && pwrite;
  always_ff @(posedge clock) begin
    if (sys_rst) mode_q <= 2'h0;
    else if (wr_acc && paddr == 12'h000) mode_q <= pwdata[1:0];
  end
  always_ff @(posedge clock) begin
    if (sys_rst) cfg_q <= 2'h0;
    else if (wr_acc && paddr == 12'h01c) cfg_q <= pwdata[1:0];
  end
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence stop_wr_s;
    wr_acc && paddr == 12'h004 && (pwdata[0] || pwdata[14]);
  endsequence
  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_error: assert property (pready && paddr > 12'h01c
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not flagged");
  a_stop_on_cmd:
    assert property (stop_wr_s |-> ##[1:3] engine_stop)
    else $error("stop command gave no engine stop");
  a_reset_quiet:
    assert property (disable iff (1'b0) sys_rst |=>
      !engine_start && !engine_creep && !jog_a && !jog_b)
    else $error("outputs active after reset");
  a_jog_needs_key:
    assert property (jog_a || jog_b |-> mode_q == 2'h0 && cfg_q == 2'h0)
    else $error("jog outside shuttle mode with key setting");
  a_jog_exclusive:
    assert property (jog_a |-> !jog_b)
    else $error("both jog pulses at once");
  a_creep_mode:
    assert property (engine_creep |-> mode_q == 2'h0 || mode_q == 2'h3)
    else $error("creep outside a shuttle capable mode");
endmodule // eipm_chk

// ### dv/eipm_top_tb.sv
// self-checking bench for the external-input positioning block
`timescale 1ns/1ps
`include "eipm_params.svh"
module eipm_top_tb;
  logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        in_a, in_b, engine_done, engine_start, engine_stop;
  logic        engine_creep, jog_a, jog_b, err_bit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] engine_target;
  int          err_count, n_compared, n_start, n_jog, j, s;

  eipm_top #(.TWO_PT_DB(8), .REMOTE_DB(4)) dut (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_a(in_a), .in_b(in_b),
    .engine_done(engine_done), .engine_start(engine_start),
    .engine_stop(engine_stop), .engine_creep(engine_creep),
    .engine_target(engine_target), .jog_a(jog_a), .jog_b(jog_b));
  eipm_engine_model u_eng (.clock(clock), .sys_rst(sys_rst),
    .engine_start(engine_start), .engine_stop(engine_stop),
    .engine_done(engine_done));

  initial clock = 1'b0;
  always #50 clock = ~clock;
  always @(posedge clock) begin
    if (engine_start === 1'b1) n_start++;
    if (jog_a === 1'b1 || jog_b === 1'b1) n_jog++;
  end
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one idle edge first, so psel is never set twice in one step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // the watchdog ends a wait that never sees pready
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    err_bit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8000) @(posedge clock);
    err_count++;
    give_verdict;
  end
  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  initial begin
    {sys_rst, psel, penable, pwrite, in_a, in_b} = 6'h20;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    rd(`EIPM_OFF_MODE);
    chk(q, 32'h0);
    rd(`EIPM_OFF_STATUS);
    chk(q, 32'h4);
    rd(12'h020);
    chk(q, 32'h0);
    chk(err_bit, 32'h1);
    for (int m = 3; m >= 0; m--) begin
      wr(`EIPM_OFF_MODE, m);
      rd(`EIPM_OFF_MODE);
      chk(q, m);
    end
    wr(`EIPM_OFF_CMD, 32'h2);
    tick(3);
    rd(`EIPM_OFF_STATUS);
    chk(q[1], 32'h1);
    chk(engine_creep, 32'h1);
    wr(`EIPM_OFF_SETVAL, 32'h123);
    wr(`EIPM_OFF_CMD, 32'h0);
    tick(3);
    rd(`EIPM_OFF_STATUS);
    chk(q[1], 32'h0);
    chk(engine_target, 32'h123);
    in_a <= 1'b1;
    in_b <= 1'b1;
    // the move to the set value must finish before the switch is obeyed
    tick(70);
    rd(`EIPM_OFF_STATUS);
    chk(q[1], 32'h1);
    wr(`EIPM_OFF_CMD, 32'h0);
    rd(`EIPM_OFF_STATUS);
    chk(q[1], 32'h1);
    in_a <= 1'b0;
    in_b <= 1'b0;
    tick(20);
    rd(`EIPM_OFF_STATUS);
    chk(q[1], 32'h0);
    j = n_jog;
    in_a <= 1'b1;
    tick(20);
    in_a <= 1'b0;
    wr(`EIPM_OFF_CONFIG, 32'h1);
    in_b <= 1'b1;
    tick(20);
    in_b <= 1'b0;
    chk(n_jog - j, 32'h1);
    wr(`EIPM_OFF_CONFIG, 32'h0);
    wr(`EIPM_OFF_MODE, 32'h1);
    wr(`EIPM_OFF_POS_ONE, 32'h100);
    wr(`EIPM_OFF_POS_TWO, 32'h200);
    in_a <= 1'b1;
    tick(20);
    chk(engine_target, 32'h100);
    rd(`EIPM_OFF_STATUS);
    chk(q[3], 32'h1);
    wr(`EIPM_OFF_SETVAL, 32'h55);
    rd(`EIPM_OFF_SETVAL);
    chk(q, 32'h100);
    wr(`EIPM_OFF_CMD, 32'h1);
    in_a <= 1'b0;
    in_b <= 1'b1;
    tick(20);
    chk(engine_target, 32'h200);
    wr(`EIPM_OFF_CMD, 32'h4000);
    in_a <= 1'b1;
    tick(20);
    rd(`EIPM_OFF_STATUS);
    chk(q[3], 32'h0);
    in_a <= 1'b0;
    in_b <= 1'b0;
    wr(`EIPM_OFF_MODE, 32'h2);
    tick(20);
    s = n_start;
    in_a <= 1'b1;
    tick(20);
    chk(n_start - s, 32'h0);
    in_a <= 1'b0;
    tick(20);
    wr(`EIPM_OFF_TARGET, 32'h300);
    wr(`EIPM_OFF_TARGET, 32'h280);
    rd(`EIPM_OFF_STATUS);
    chk(q[2], 32'h0);
    in_a <= 1'b1;
    in_b <= 1'b1;
    tick(20);
    chk(engine_target, 32'h280);
    wr(`EIPM_OFF_TARGET, 32'h99);
    rd(`EIPM_OFF_TARGET);
    chk(q, 32'h280);
    rd(`EIPM_OFF_STATUS);
    chk(q[4], 32'h1);
    in_a <= 1'b0;
    tick(20);
    rd(`EIPM_OFF_STATUS);
    chk(q[2], 32'h1);
    wr(`EIPM_OFF_TARGET, 32'h280);
    in_a <= 1'b1;
    tick(90);
    rd(`EIPM_OFF_STATUS);
    chk(q[2], 32'h1);
    in_a <= 1'b0;
    in_b <= 1'b0;
    wr(`EIPM_OFF_MODE, 32'h3);
    tick(20);
    j = n_jog;
    in_a <= 1'b1;
    tick(20);
    chk(n_jog - j, 32'h0);
    in_b <= 1'b1;
    tick(20);
    rd(`EIPM_OFF_STATUS);
    chk(q[1], 32'h0);
    wr(`EIPM_OFF_CMD, 32'h2);
    tick(3);
    rd(`EIPM_OFF_STATUS);
    chk(q[1], 32'h1);
    give_verdict;
  end
endmodule // eipm_top_tb

bind eipm_top eipm_chk u_chk (
  .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .engine_start(engine_start),
  .engine_stop(engine_stop), .engine_creep(engine_creep),
  .jog_a(jog_a), .jog_b(jog_b));
